// ---- plock_defines.svh ----
// constant definitions for the panel lock control block
`ifndef PLOCK_DEFINES_SVH
`define PLOCK_DEFINES_SVH
`define PLOCK_CLK_HZ 125000000
`define PLOCK_SCROLL_MS 1500
`define PLOCK_SCROLL_CYC ((`PLOCK_CLK_HZ / 1000) * `PLOCK_SCROLL_MS)
`define PLOCK_HOLD_MS 500
`define PLOCK_HOLD_CYC ((`PLOCK_CLK_HZ / 1000) * `PLOCK_HOLD_MS)
`define PLOCK_FAST_MS 100
`define PLOCK_FAST_CYC ((`PLOCK_CLK_HZ / 1000) * `PLOCK_FAST_MS)
`define PLOCK_AGGR_MAX 8'sh09
`define PLOCK_AGGR_MIN (-8'sh09)
`define PLOCK_AGGR_RST 8'sh00
`define PLOCK_LEVEL_RST 2'h3
`define PLOCK_VAL_RST 8'h00
// apb register byte addresses
`define PLOCK_A_CTRL 12'h000
`define PLOCK_A_AGGR 12'h004
`define PLOCK_A_STAT 12'h008
`define PLOCK_A_CMD 12'h00c
`define PLOCK_A_VAL 12'h010
// ctrl field positions
`define PLOCK_CTRL_LVL_LO 0
`define PLOCK_CTRL_STAT_BIT 4
// cmd field positions
`define PLOCK_CMD_TFAIL_BIT 0
`define PLOCK_CMD_TCLR_BIT 1
`define PLOCK_CMD_MODE_LO 4
`define PLOCK_CMD_MODE_GO_BIT 8
`endif

// ---- plock_operator.sv ----
// operator model: three pushbuttons and the configuration-lock jumper
`timescale 1ns/100ps
module plock_operator (
  // clock
  input wire logic clk_i,
  // panel controls
  output logic btn_sel_o,
  output logic btn_dec_o,
  output logic btn_inc_o,
  output logic jumper_secure_o
);
  // idle: buttons released, jumper open
  initial begin
    btn_sel_o = 1'b0;
    btn_dec_o = 1'b0;
    btn_inc_o = 1'b0;
    jumper_secure_o = 1'b0;
  end

  // hold one button (0 select, 1 minus, 2 plus) for some cycles
  task automatic press(input int which, input int cycles);
    case (which)
      0: btn_sel_o <= 1'b1;
      1: btn_dec_o <= 1'b1;
      default: btn_inc_o <= 1'b1;
    endcase
    repeat (cycles) @(posedge clk_i);
    btn_sel_o <= 1'b0;
    btn_dec_o <= 1'b0;
    btn_inc_o <= 1'b0;
    // a real finger leaves a gap, so the panel settles first
    repeat (3) @(posedge clk_i);
  endtask : press

  // move the jumper; a person cannot flip it within one cycle
  task automatic set_jumper(input logic secure);
    jumper_secure_o <= secure;
    repeat (2) @(posedge clk_i);
  endtask : set_jumper

  // commissioning walk: manual, then setup, then calibration
  task automatic commission();
    repeat (3) press(0, 1);
  endtask : commission
endmodule : plock_operator

// ---- plock_panel.sv ----
// panel lock control: buttons, locks, modes and display selection
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/100ps
`include "plock_defines.svh"
module plock_panel #(
  parameter int SCROLL_CYC = `PLOCK_SCROLL_CYC,
  parameter int HOLD_CYC = `PLOCK_HOLD_CYC,
  parameter int FAST_CYC = `PLOCK_FAST_CYC
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // panel inputs
  input wire logic btn_sel_i,
  input wire logic btn_dec_i,
  input wire logic btn_inc_i,
  input wire logic jumper_secure_i,
  // valve side
  input wire logic [7:0] analog_setpt_i,
  input wire logic [7:0] position_i,
  // display and mode outputs
  output logic [2:0] show_o,
  output logic status_mark_o,
  output logic [2:0] mode_o,
  output logic [7:0] valve_cmd_o,
  output logic [7:0] edit_val_o,
  output logic signed [7:0] aggr_o,
  output logic tune_err_o
);
  if (SCROLL_CYC < 1 || HOLD_CYC < 1 || FAST_CYC < 1) begin : g_bad_counts
    $error("plock_panel: counts must be at least one");
  end

  plock_pkg::plock_mode_t mode_reg;
  plock_pkg::plock_show_t show_reg;
  logic [1:0] level_reg;
  logic stat_reg, status_mark_reg;
  logic signed [7:0] aggr_reg;
  logic tune_err_reg;
  logic [7:0] val_reg, hold_pos_reg, valve_reg;
  logic [31:0] scroll_cnt_reg;
  logic [31:0] hold_cnt_reg;
  logic [2:0] btn_prev_reg;
  logic [31:0] prdata_reg;
  logic pready_reg, pslverr_reg;

  // apb decode
  logic acc, wr_ctrl, wr_aggr, wr_cmd, wr_val, hit;
  logic signed [7:0] aggr_w;
  assign acc = psel_i & penable_i & ce_i;
  assign hit = (paddr_i == `PLOCK_A_CTRL) || (paddr_i == `PLOCK_A_AGGR) ||
               (paddr_i == `PLOCK_A_STAT) || (paddr_i == `PLOCK_A_CMD) ||
               (paddr_i == `PLOCK_A_VAL);
  assign wr_ctrl = acc & pwrite_i & (paddr_i == `PLOCK_A_CTRL);
  assign wr_aggr = acc & pwrite_i & (paddr_i == `PLOCK_A_AGGR);
  assign wr_cmd = acc & pwrite_i & (paddr_i == `PLOCK_A_CMD);
  assign wr_val = acc & pwrite_i & (paddr_i == `PLOCK_A_VAL);
  assign aggr_w = pwdata_i[7:0];

  // remote mode command; jumper blocks config and calib entry remotely
  logic rmode_go, rmode_ok;
  plock_pkg::plock_mode_t rmode;
  assign rmode_go = wr_cmd & pwdata_i[`PLOCK_CMD_MODE_GO_BIT];
  assign rmode = plock_pkg::plock_mode_t'(pwdata_i[`PLOCK_CMD_MODE_LO +: 3]);
  assign rmode_ok = !(jumper_secure_i && (rmode == plock_pkg::PLOCK_CONFIG ||
                     rmode == plock_pkg::PLOCK_CALIB));

  // button edges and hold repeat
  logic [2:0] btn_now, btn_rise;
  logic rep_tick, any_btn;
  assign btn_now = {btn_inc_i, btn_dec_i, btn_sel_i};
  assign btn_rise = btn_now & ~btn_prev_reg;
  assign any_btn = |btn_rise;
  assign rep_tick = (btn_inc_i ^ btn_dec_i) && hold_cnt_reg >= 32'(HOLD_CYC) &&
    ((hold_cnt_reg - 32'(HOLD_CYC)) % 32'(FAST_CYC)) == 0;

  // permission: most restrictive of level and jumper
  logic eff1, allow_manual, allow_setup, allow_any, refused;
  assign allow_any = (level_reg != 2'h0);
  assign allow_manual = (level_reg >= 2'h2);
  assign allow_setup = (level_reg == 2'h3) && !jumper_secure_i;
  assign eff1 = allow_any;

  // next mode requested by select press
  plock_pkg::plock_mode_t sel_target;
  logic sel_ok;
  always_comb begin
    sel_target = plock_pkg::PLOCK_NORMAL;
    sel_ok = 1'b0;
    case (mode_reg)
      plock_pkg::PLOCK_NORMAL: begin
        sel_target = plock_pkg::PLOCK_MANUAL;
        sel_ok = allow_manual;
      end
      plock_pkg::PLOCK_MANUAL: begin
        sel_target = plock_pkg::PLOCK_CONFIG;
        sel_ok = allow_setup;
      end
      plock_pkg::PLOCK_CONFIG: begin
        sel_target = plock_pkg::PLOCK_CALIB;
        sel_ok = allow_setup;
      end
      plock_pkg::PLOCK_CALIB: begin
        sel_target = plock_pkg::PLOCK_NORMAL;
        sel_ok = 1'b1;
      end
      default: begin
        sel_target = mode_reg;
        sel_ok = 1'b0;
      end
    endcase
  end

  logic edit_mode;
  assign edit_mode = (mode_reg == plock_pkg::PLOCK_MANUAL && allow_manual) ||
                     ((mode_reg == plock_pkg::PLOCK_CONFIG ||
                       mode_reg == plock_pkg::PLOCK_CALIB) && allow_setup);

  // mode machine: reset mode after power-up, then normal
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_reg <= plock_pkg::PLOCK_RESET;
    end else if (ce_i) begin
      case (mode_reg)
        plock_pkg::PLOCK_RESET: begin
          mode_reg <= plock_pkg::PLOCK_NORMAL;
        end
        default: begin
          if (rmode_go && rmode_ok && rmode <= plock_pkg::PLOCK_FAILSAFE) begin
            mode_reg <= rmode;
          end else if (btn_rise[0] && eff1 && sel_ok) begin
            mode_reg <= sel_target;
          end
        end
      endcase
    end
  end

  // software lock level, status flag and the status symbol flop
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_reg <= `PLOCK_LEVEL_RST;
      stat_reg <= 1'b0;
      status_mark_reg <= 1'b0;
    end else if (ce_i) begin
      if (wr_ctrl) begin
        level_reg <= pwdata_i[`PLOCK_CTRL_LVL_LO +: 2];
        stat_reg <= pwdata_i[`PLOCK_CTRL_STAT_BIT];
      end
      status_mark_reg <= stat_reg | tune_err_reg;
    end
  end

  // aggressiveness: remote only, clamped range, kept until changed
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aggr_reg <= `PLOCK_AGGR_RST;
    end else if (ce_i && wr_aggr && !jumper_secure_i) begin
      if (aggr_w > `PLOCK_AGGR_MAX) begin
        aggr_reg <= `PLOCK_AGGR_MAX;
      end else if (aggr_w < `PLOCK_AGGR_MIN) begin
        aggr_reg <= `PLOCK_AGGR_MIN;
      end else begin
        aggr_reg <= aggr_w;
      end
    end
  end

  // tune failure flag; a new failure wins over a clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tune_err_reg <= 1'b0;
    end else if (ce_i) begin
      if (wr_cmd && pwdata_i[`PLOCK_CMD_TFAIL_BIT]) begin
        tune_err_reg <= 1'b1;
      end else if (wr_cmd && pwdata_i[`PLOCK_CMD_TCLR_BIT]) begin
        tune_err_reg <= 1'b0;
      end
    end
  end

  // edited value: step, fast repeat, remote load
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      val_reg <= `PLOCK_VAL_RST;
    end else if (ce_i) begin
      if (wr_val && (!jumper_secure_i ||
                     mode_reg == plock_pkg::PLOCK_MANUAL)) begin
        val_reg <= pwdata_i[7:0];
      end else if (edit_mode && (btn_rise[2] ||
                                 (rep_tick && btn_inc_i))) begin
        val_reg <= val_reg + 8'h01;
      end else if (edit_mode && (btn_rise[1] ||
                                 (rep_tick && btn_dec_i))) begin
        val_reg <= val_reg - 8'h01;
      end
    end
  end

  // captured position on entry to manual from normal
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_pos_reg <= 8'h00;
    end else if (ce_i) begin
      if (mode_reg == plock_pkg::PLOCK_NORMAL &&
          ((btn_rise[0] && eff1 && sel_ok) ||
           (rmode_go && rmode == plock_pkg::PLOCK_MANUAL))) begin
        hold_pos_reg <= position_i;
      end else if (mode_reg == plock_pkg::PLOCK_MANUAL && wr_val) begin
        hold_pos_reg <= pwdata_i[7:0];
      end else if (mode_reg == plock_pkg::PLOCK_MANUAL && edit_mode &&
                   btn_rise[2]) begin
        hold_pos_reg <= val_reg + 8'h01;
      end else if (mode_reg == plock_pkg::PLOCK_MANUAL && edit_mode &&
                   btn_rise[1]) begin
        hold_pos_reg <= val_reg - 8'h01;
      end
    end
  end

  // valve command: analog in normal, held value in manual
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      valve_reg <= 8'h00;
    end else if (ce_i) begin
      if (mode_reg == plock_pkg::PLOCK_NORMAL) begin
        valve_reg <= analog_setpt_i;
      end else if (mode_reg == plock_pkg::PLOCK_MANUAL) begin
        valve_reg <= hold_pos_reg;
      end
    end
  end

  // button history and hold counter
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      btn_prev_reg <= 3'h0;
      hold_cnt_reg <= 32'h0;
    end else if (ce_i) begin
      btn_prev_reg <= btn_now;
      if (btn_inc_i ^ btn_dec_i) begin
        hold_cnt_reg <= hold_cnt_reg + 32'h1;
      end else begin
        hold_cnt_reg <= 32'h0;
      end
    end
  end

  // scroll timer; a refusal restarts it so the locked page stands
  logic scroll_tick;
  assign scroll_tick = (scroll_cnt_reg == 32'(SCROLL_CYC - 1));
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scroll_cnt_reg <= 32'h0;
    end else if (ce_i) begin
      if (mode_reg != plock_pkg::PLOCK_NORMAL || scroll_tick || refused) begin
        scroll_cnt_reg <= 32'h0;
      end else begin
        scroll_cnt_reg <= scroll_cnt_reg + 32'h1;
      end
    end
  end

  // display selection; no diagnostics page exists
  assign refused = any_btn && (!eff1 || (btn_rise[0] && !sel_ok) ||
                   (!btn_rise[0] && !edit_mode &&
                    mode_reg != plock_pkg::PLOCK_NORMAL));
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      show_reg <= plock_pkg::PLOCK_SHOW_SETPT;
    end else if (ce_i) begin
      if (refused) begin
        show_reg <= plock_pkg::PLOCK_SHOW_LOCKED;
      end else if (tune_err_reg) begin
        show_reg <= plock_pkg::PLOCK_SHOW_TUNE_ERROR_MESSAGE;
      end else if (show_reg == plock_pkg::PLOCK_SHOW_LOCKED && !any_btn &&
                   !scroll_tick) begin
        show_reg <= plock_pkg::PLOCK_SHOW_LOCKED;
      end else if (mode_reg != plock_pkg::PLOCK_NORMAL) begin
        show_reg <= edit_mode ? plock_pkg::PLOCK_SHOW_VALUE
                              : plock_pkg::PLOCK_SHOW_MENU;
      end else if (scroll_tick ||
                   show_reg > plock_pkg::PLOCK_SHOW_POS) begin
        case (show_reg)
          plock_pkg::PLOCK_SHOW_SETPT: show_reg <= plock_pkg::PLOCK_SHOW_PRES;
          plock_pkg::PLOCK_SHOW_PRES: show_reg <= plock_pkg::PLOCK_SHOW_POS;
          default: show_reg <= plock_pkg::PLOCK_SHOW_SETPT;
        endcase
      end
    end
  end

  // apb read data and answer, zero wait states
  logic [31:0] rd;
  always_comb begin
    rd = 32'h0;
    if (paddr_i == `PLOCK_A_CTRL) begin
      rd = {27'h0, stat_reg, 2'h0, level_reg};
    end else if (paddr_i == `PLOCK_A_AGGR) begin
      rd = {{24{aggr_reg[7]}}, aggr_reg};
    end else if (paddr_i == `PLOCK_A_STAT) begin
      rd = {19'h0, valve_reg, tune_err_reg, jumper_secure_i, mode_reg};
    end else if (paddr_i == `PLOCK_A_VAL) begin
      rd = {24'h0, val_reg};
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_reg <= 32'h0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else if (ce_i) begin
      pready_reg <= psel_i & ~penable_i;
      pslverr_reg <= psel_i & ~penable_i & ~hit;
      prdata_reg <= (psel_i & ~penable_i & ~pwrite_i) ? rd : 32'h0;
    end
  end

  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign show_o = show_reg;
  assign status_mark_o = status_mark_reg;
  assign mode_o = mode_reg;
  assign valve_cmd_o = valve_reg;
  assign edit_val_o = val_reg;
  assign aggr_o = aggr_reg;
  assign tune_err_o = tune_err_reg;

  // checks
  chk_aggr_range: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    aggr_reg <= `PLOCK_AGGR_MAX && aggr_reg >= `PLOCK_AGGR_MIN)
    else $error("aggressiveness out of range");
  chk_lvl0_mode: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && level_reg == 2'h0 && btn_rise[0] && !rmode_go
    |=> $stable(mode_reg))
    else $error("mode moved at level zero");
  chk_jumper_setup: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && jumper_secure_i && mode_reg == plock_pkg::PLOCK_MANUAL
    && !rmode_go |=> mode_reg != plock_pkg::PLOCK_CONFIG)
    else $error("setup entered with jumper secure");
  chk_locked_msg: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && refused |=> show_reg == plock_pkg::PLOCK_SHOW_LOCKED)
    else $error("locked message missing");
  chk_tune_show: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && tune_err_reg && !refused
    |=> show_reg == plock_pkg::PLOCK_SHOW_TUNE_ERROR_MESSAGE)
    else $error("tune error not shown");
  chk_manual_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && mode_reg == plock_pkg::PLOCK_MANUAL && $stable(hold_pos_reg)
    |=> valve_reg == $past(hold_pos_reg))
    else $error("manual mode follows analog input");
  chk_scroll_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && scroll_tick && !refused && !tune_err_reg
    && show_reg == plock_pkg::PLOCK_SHOW_SETPT
    |=> show_reg == plock_pkg::PLOCK_SHOW_PRES)
    else $error("scroll did not advance");
  chk_lvl1_manual: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && level_reg == 2'h1 && mode_reg == plock_pkg::PLOCK_NORMAL
    && !rmode_go |=> mode_reg != plock_pkg::PLOCK_MANUAL)
    else $error("manual entered at level one");
endmodule : plock_panel

// ---- plock_pkg.sv ----
// types for the panel lock control block
package plock_pkg;
  typedef enum logic [2:0] {
    PLOCK_NORMAL = 3'b000,
    PLOCK_MANUAL = 3'b001,
    PLOCK_CONFIG = 3'b010,
    PLOCK_CALIB = 3'b011,
    PLOCK_RESET = 3'b100,
    PLOCK_FAILSAFE = 3'b101
  } plock_mode_t;
  typedef enum logic [2:0] {
    PLOCK_SHOW_SETPT = 3'b000,
    PLOCK_SHOW_PRES = 3'b001,
    PLOCK_SHOW_POS = 3'b010,
    PLOCK_SHOW_LOCKED = 3'b011,
    PLOCK_SHOW_TUNE_ERROR_MESSAGE = 3'b100,
    PLOCK_SHOW_MENU = 3'b101,
    PLOCK_SHOW_VALUE = 3'b110
  } plock_show_t;
endpackage : plock_pkg

// ---- plock_tb.sv ----
// self-checking bench for the panel lock control block
`timescale 1ns/100ps
`include "plock_defines.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
  err_total++; $display("unexpected at %0t: got %h exp %h", $time, g, e); \
  end end
module tb;
  localparam int SCROLL = 20;
  localparam int HOLD = 8;
  localparam int FAST = 2;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic bsel, bdec, binc, jmp;
  logic [7:0] setpt = 8'h00;
  logic [7:0] pos = 8'h00;
  logic [2:0] show, mode;
  logic smark, terr;
  logic [7:0] vcmd, eval;
  logic signed [7:0] aggr;
  int err_total = 0;
  int comparisons = 0;
  logic [31:0] seed = 32'h00016bde;
  logic [31:0] rd;
  logic slv;
  int tbl[6] = '{9, 10, -9, -10, 0, 127};

  // free-running clock
  always #4 clk_i = ~clk_i;

  plock_panel #(.SCROLL_CYC(SCROLL), .HOLD_CYC(HOLD), .FAST_CYC(FAST))
    i_plock_panel (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .btn_sel_i(bsel), .btn_dec_i(bdec),
    .btn_inc_i(binc), .jumper_secure_i(jmp), .analog_setpt_i(setpt),
    .position_i(pos), .show_o(show), .status_mark_o(smark), .mode_o(mode),
    .valve_cmd_o(vcmd), .edit_val_o(eval), .aggr_o(aggr),
    .tune_err_o(terr));

  plock_operator i_plock_operator (.clk_i(clk_i), .btn_sel_o(bsel),
    .btn_dec_o(bdec), .btn_inc_o(binc), .jumper_secure_o(jmp));

  // next random word
  function automatic logic [31:0] nxt(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt

  // aggressiveness after clamping to the accepted span
  function automatic logic [7:0] clampv(int v);
    return (v > 9) ? 8'h09 : (v < -9) ? 8'hf7 : v[7:0];
  endfunction : clampv

  // one apb transfer; waits for pready, then releases
  task automatic xfer(input logic [11:0] a, input logic w,
                      input logic [31:0] d);
    psel <= 1'b1;
    pen <= 1'b0;
    paddr <= a;
    pwr <= w;
    pwdata <= d;
    @(posedge clk_i);
    pen <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk_i);
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask : wr

  task automatic rdr(input logic [11:0] a);
    xfer(a, 1'b0, 32'h0);
  endtask : rdr

  task automatic ctrl(input logic [1:0] lvl, input logic st);
    wr(`PLOCK_A_CTRL, {27'h0, st, 2'h0, lvl});
  endtask : ctrl

  task automatic setm(input logic [2:0] m);
    wr(`PLOCK_A_CMD, {23'h0, 1'b1, 1'b0, m, 4'h0});
    repeat (2) @(posedge clk_i);
  endtask : setm

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  // counts and verdict, then stop
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  // watchdog far beyond the few hundred cycles the tests need
  initial begin
    #400000;
    err_total++;
    $display("unexpected at %0t: watchdog expired", $time);
    print_verdict();
  end

  // main sequence
  initial begin
    int cnt, av, i;
    logic [2:0] s0;
    logic [7:0] ex, p, val, e0;
    repeat (5) @(posedge clk_i);
    `CHK(mode, plock_pkg::PLOCK_RESET)
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    `CHK(mode, plock_pkg::PLOCK_NORMAL)
    rdr(`PLOCK_A_CTRL);
    `CHK(rd[1:0], 2'h3)
    rdr(12'h020);
    `CHK({slv, rd}, {1'b1, 32'h0})
    done("registers");
    // scroll period and page order
    for (i = 0; i < 2; i++) begin
      s0 = show;
      cnt = 0;
      while (show === s0 && cnt < 3 * SCROLL) begin
        @(posedge clk_i);
        cnt++;
      end
    end
    `CHK(cnt, SCROLL)
    `CHK(show, (s0 === 3'h2) ? 3'h0 : s0 + 3'h1)
    done("scroll");
    // aggressiveness: corners then random values
    for (i = 0; i < 12; i++) begin
      av = (i < 6) ? tbl[i] : int'($signed(seed[4:0]));
      seed = nxt(seed);
      ex = clampv(av);
      wr(`PLOCK_A_AGGR, av);
      rdr(`PLOCK_A_AGGR);
      `CHK(rd, {{24{ex[7]}}, ex})
      `CHK(aggr, ex)
    end
    i_plock_operator.set_jumper(1'b1);
    wr(`PLOCK_A_AGGR, (ex == 8'h00) ? 32'h1 : 32'h0);
    `CHK(aggr, ex)
    i_plock_operator.set_jumper(1'b0);
    wr(`PLOCK_A_CMD, 32'h1);
    `CHK(terr, 1'b1)
    rdr(`PLOCK_A_STAT);
    `CHK(rd[4], 1'b1)
    `CHK(smark, 1'b1)
    wr(`PLOCK_A_CMD, 32'h3);
    `CHK(terr, 1'b1)
    wr(`PLOCK_A_CMD, 32'h2);
    `CHK(terr, 1'b0)
    `CHK(aggr, ex)
    done("aggressiveness");
    // lock levels against select presses
    for (i = 0; i < 4; i++) begin
      setm(plock_pkg::PLOCK_NORMAL);
      ctrl(i[1:0], 1'b0);
      i_plock_operator.press(0, 1);
      `CHK(mode, (i >= 2) ? 3'h1 : 3'h0)
      if (i < 2) `CHK(show, plock_pkg::PLOCK_SHOW_LOCKED)
      if (i == 0) i_plock_operator.press(2, 1);
      if (i == 0) `CHK(show, plock_pkg::PLOCK_SHOW_LOCKED)
      if (i >= 2) i_plock_operator.press(0, 1);
      if (i >= 2) `CHK(mode, (i == 3) ? 3'h2 : 3'h1)
    end
    setm(plock_pkg::PLOCK_NORMAL);
    i_plock_operator.set_jumper(1'b1);
    i_plock_operator.press(0, 1);
    i_plock_operator.press(0, 1);
    `CHK(mode, plock_pkg::PLOCK_MANUAL)
    `CHK(show, plock_pkg::PLOCK_SHOW_LOCKED)
    setm(plock_pkg::PLOCK_CALIB);
    `CHK(mode, plock_pkg::PLOCK_MANUAL)
    rdr(`PLOCK_A_STAT);
    `CHK(rd[3], 1'b1)
    i_plock_operator.set_jumper(1'b0);
    done("locks");
    // manual mode: held position, remote positioning, editing
    setm(plock_pkg::PLOCK_NORMAL);
    p = seed[7:0];
    pos <= p;
    setpt <= seed[15:8];
    seed = nxt(seed);
    @(posedge clk_i);
    i_plock_operator.press(0, 1);
    `CHK(mode, plock_pkg::PLOCK_MANUAL)
    `CHK(vcmd, p)
    pos <= ~p;
    setpt <= ~setpt;
    repeat (3) @(posedge clk_i);
    `CHK(vcmd, p)
    val = {2'h0, seed[5:0]} + 8'h10;
    wr(`PLOCK_A_VAL, {24'h0, val});
    @(posedge clk_i);
    `CHK(vcmd, val)
    e0 = eval;
    i_plock_operator.press(2, 1);
    `CHK(eval, e0 + 8'h01)
    i_plock_operator.press(1, 1);
    `CHK(eval, e0)
    i_plock_operator.press(2, HOLD + 4 * FAST);
    `CHK((eval - e0) > 8'h02, 1'b1)
    e0 = eval;
    i_plock_operator.press(1, HOLD + 4 * FAST);
    `CHK((e0 - eval) > 8'h02, 1'b1)
    `CHK(aggr, ex)
    done("manual");
    // remote mode changes and status symbol
    for (i = 0; i < 6; i++) begin
      setm(i[2:0]);
      `CHK(mode, (i == 4) ? 3'h0 : i[2:0])
      rdr(`PLOCK_A_STAT);
      `CHK(rd[2:0], (i == 4) ? 3'h0 : i[2:0])
    end
    i_plock_operator.press(0, 1);
    `CHK(mode, plock_pkg::PLOCK_FAILSAFE)
    `CHK(show, plock_pkg::PLOCK_SHOW_LOCKED)
    ctrl(2'h3, 1'b1);
    @(posedge clk_i);
    `CHK(smark, 1'b1)
    ctrl(2'h3, 1'b0);
    @(posedge clk_i);
    `CHK(smark, 1'b0)
    setm(plock_pkg::PLOCK_NORMAL);
    i_plock_operator.commission();
    `CHK(mode, plock_pkg::PLOCK_CALIB)
    ce <= 1'b0;
    i_plock_operator.press(0, 1);
    `CHK(mode, plock_pkg::PLOCK_CALIB)
    ce <= 1'b1;
    done("modes");
    print_verdict();
  end
endmodule : tb
